/* ppp_sync.sv */
package ppp_pkg;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int ENTRY_QUIET_NS = 100;
	localparam int ENTRY_QUIET_CYC = (ENTRY_QUIET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [2:0] ENTRY_TOGGLE_MIN = 3'h6;

	// ----------------------------------------------------------------
	// Pin encodings
	// ----------------------------------------------------------------
	localparam logic [1:0] SA_ADDR = 2'h0;
	localparam logic [1:0] SA_DATA = 2'h1;
	localparam logic [1:0] SA_CMD = 2'h2;
	localparam logic [1:0] BS_LOW = 2'h0;
	localparam logic [1:0] BS_HIGH = 2'h1;
	localparam logic [1:0] BS_EXT = 2'h2;
	localparam logic [1:0] BS_FHIGH = 2'h3;
	localparam logic [3:0] ENTRY_PATTERN = 4'h0;

	// ----------------------------------------------------------------
	// Command bytes
	// ----------------------------------------------------------------
	localparam logic [7:0] CMD_NOP = 8'h00;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_WR_FUSE = 8'h40;
	localparam logic [7:0] CMD_WR_LOCK = 8'h20;
	localparam logic [7:0] CMD_WR_FLASH = 8'h10;
	localparam logic [7:0] CMD_WR_EE = 8'h11;
	localparam logic [7:0] CMD_RD_SIG = 8'h08;
	localparam logic [7:0] CMD_RD_FUSE = 8'h04;
	localparam logic [7:0] CMD_RD_FLASH = 8'h02;
	localparam logic [7:0] CMD_RD_EE = 8'h03;

	// ----------------------------------------------------------------
	// Configuration bytes and page geometry
	// ----------------------------------------------------------------
	localparam logic [7:0] FUSE_LO_RST = 8'h62;
	localparam logic [7:0] FUSE_HI_RST = 8'h99;
	localparam logic [7:0] FUSE_EXT_RST = 8'hff;
	localparam logic [7:0] LOCK_RST = 8'hff;
	localparam logic [7:0] LOCK_ERASED = 8'hff;
	localparam int KEEP_EE_BIT = 3;
	localparam int PAGE_WORD_BITS = 6;
	localparam int PAGE_WORDS = 64;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		MODE_OFF = 2'b00,
		MODE_ENTRY = 2'b01,
		MODE_PROG = 2'b10,
		MODE_FAIL = 2'b11
	} ppp_mode_e;

	typedef enum logic [2:0] {
		OP_NONE = 3'b000,
		OP_ERASE = 3'b001,
		OP_FLASH_PAGE = 3'b010,
		OP_EE_PAGE = 3'b011,
		OP_FUSE = 3'b100,
		OP_LOCK = 3'b101
	} ppp_op_e;

	typedef struct packed {
		logic qualify;
		logic page_latch;
		logic load_strobe;
		logic [1:0] strobe_action;
		logic byte_select_hi;
		logic byte_select_lo;
		logic write_strobe_n;
		logic output_enable_n;
		logic [7:0] data;
	} ppp_pins_s;

	localparam ppp_pins_s PINS_RST = '{
		qualify: 1'b0, page_latch: 1'b0, load_strobe: 1'b0, strobe_action: 2'h3,
		byte_select_hi: 1'b0, byte_select_lo: 1'b0, write_strobe_n: 1'b1,
		output_enable_n: 1'b1, data: 8'h00
	};

	typedef struct packed {
		logic start;
		ppp_op_e op;
		logic [23:0] addr;
		logic [7:0] wdata;
		logic keep_eeprom;
	} ppp_nvm_req_s;

endpackage

`timescale 1ns/1ps
`default_nettype none

// Two-stage synchroniser for the programming pins
module ppp_sync #(
	parameter int W = 17,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// Data
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] meta_ff;

	// ----------------------------------------------------------------
	// Synchroniser chain
	// ----------------------------------------------------------------
	// Only the second stage is visible, so metastability stays inside
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			meta_ff <= RST_VAL;
			o_q <= RST_VAL;
		end else if (i_ce) begin
			meta_ff <= i_d;
			o_q <= meta_ff;
		end
	end
endmodule

`default_nettype wire

/* ppp_port.sv */
`timescale 1ns/1ps
`default_nettype none

module ppp_port
	import ppp_pkg::*;
(
	// Clock, reset, enable
	input wire logic i_clk,
	input wire logic i_arst_n,
	input wire logic i_ce,
	// Programming pins
	input wire logic i_prog_qualify,
	input wire logic i_load_strobe,
	input wire logic [1:0] i_strobe_action,
	input wire logic i_byte_select_hi,
	input wire logic i_byte_select_lo,
	input wire logic i_page_latch,
	input wire logic i_write_strobe_n,
	input wire logic i_output_enable_n,
	input wire logic [7:0] i_data,
	output logic [7:0] o_data,
	output logic o_data_oe_n,
	output logic o_ready_busy_n,
	// Status
	output logic o_prog_mode,
	// Memory side
	output ppp_nvm_req_s o_nvm_req,
	input wire logic i_nvm_done,
	input wire logic [15:0] i_flash_word,
	input wire logic [7:0] i_ee_byte,
	input wire logic [7:0] i_sig_byte,
	input wire logic [7:0] i_cal_byte,
	input wire logic [PAGE_WORD_BITS-1:0] i_pbuf_idx,
	output logic [15:0] o_pbuf_word
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		ppp_mode_e mode;
		logic [2:0] tgl_cnt;
		logic [1:0] ent_cnt;
		logic ls_q;
		logic wr_q;
		logic pl_q;
		logic [7:0] cmd;
		logic [23:0] addr;
		logic [7:0] dlo;
		logic [7:0] dhi;
		logic busy;
		logic start;
		ppp_op_e op;
		logic [1:0] fsel;
		logic [7:0] fuse_lo;
		logic [7:0] fuse_hi;
		logic [7:0] fuse_ext;
		logic [7:0] lock;
		logic [7:0] dout;
		logic oe_n;
		logic [15:0] pbuf_rd;
	} ppp_state_s;

	localparam ppp_state_s ST_RST = '{
		mode: MODE_OFF, tgl_cnt: 3'h0, ent_cnt: 2'h0, ls_q: 1'b0, wr_q: 1'b1,
		pl_q: 1'b0, cmd: CMD_NOP, addr: 24'h000000, dlo: 8'h00, dhi: 8'h00,
		busy: 1'b0, start: 1'b0, op: OP_NONE, fsel: BS_LOW, fuse_lo: FUSE_LO_RST,
		fuse_hi: FUSE_HI_RST, fuse_ext: FUSE_EXT_RST, lock: LOCK_RST,
		dout: 8'h00, oe_n: 1'b1, pbuf_rd: 16'h0000
	};

	ppp_state_s st_ff;
	ppp_state_s nxt_st;
	logic [15:0] pbuf [0:PAGE_WORDS-1];
	logic [16:0] pins_raw;
	ppp_pins_s pins;
	logic [7:0] pin_data;
	logic [1:0] bs;
	logic ls_rise;
	logic wr_fall;
	logic pl_rise;
	logic in_prog;
	logic pbuf_we;

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	ppp_sync #(
		.W(17),
		.RST_VAL(PINS_RST)
	) u_sync (
		.i_clk(i_clk),
		.i_arst_n(i_arst_n),
		.i_ce(i_ce),
		.i_d({i_prog_qualify, i_page_latch, i_load_strobe, i_strobe_action,
			i_byte_select_hi, i_byte_select_lo, i_write_strobe_n,
			i_output_enable_n, i_data}),
		.o_q(pins_raw)
	);

	// Edges are found on the synchronised copies; the load strobe is slow
	// enough (hundreds of ns) that the 20 MHz clock sees every edge.
	assign pins = ppp_pins_s'(pins_raw);
	assign pin_data = pins.data;
	assign bs = {pins.byte_select_hi, pins.byte_select_lo};
	assign in_prog = (st_ff.mode == MODE_PROG);
	assign ls_rise = in_prog && pins.load_strobe && !st_ff.ls_q;
	assign wr_fall = in_prog && !pins.write_strobe_n && st_ff.wr_q;
	assign pl_rise = in_prog && pins.page_latch && !st_ff.pl_q;
	assign pbuf_we = pl_rise && pins.byte_select_lo;

	// ----------------------------------------------------------------
	// Readback selection
	// ----------------------------------------------------------------
	function automatic logic [7:0] read_byte(input logic [7:0] cmd, input logic [1:0] sel,
			input ppp_state_s s);
		logic [7:0] r;
		r = 8'h00;
		case (cmd)
			CMD_RD_SIG: r = sel[0] ? i_cal_byte : i_sig_byte;
			CMD_RD_FUSE: begin
				case (sel)
					BS_LOW: r = s.fuse_lo;
					BS_HIGH: r = s.lock;
					BS_EXT: r = s.fuse_ext;
					default: r = s.fuse_hi;
				endcase
			end
			CMD_RD_FLASH: r = sel[0] ? i_flash_word[15:8] : i_flash_word[7:0];
			CMD_RD_EE: r = i_ee_byte;
			default: r = 8'h00;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.start = 1'b0;
		nxt_st.ls_q = pins.load_strobe;
		nxt_st.wr_q = pins.write_strobe_n;
		nxt_st.pl_q = pins.page_latch;

		// Mode entry, qualified by the single digital high-voltage level
		case (st_ff.mode)
			MODE_OFF: begin
				if (!pins.qualify) begin
					if (pins.load_strobe && !st_ff.ls_q && st_ff.tgl_cnt != 3'h7) begin
						nxt_st.tgl_cnt = st_ff.tgl_cnt + 3'h1;
					end
				end else if ({pins.page_latch, pins.strobe_action, pins.byte_select_lo}
						== ENTRY_PATTERN && st_ff.tgl_cnt >= ENTRY_TOGGLE_MIN) begin
					nxt_st.mode = MODE_ENTRY;
					nxt_st.ent_cnt = 2'h0;
				end else begin
					nxt_st.mode = MODE_FAIL;
				end
			end
			MODE_ENTRY: begin
				if (!pins.qualify) begin
					nxt_st.mode = MODE_OFF;
					nxt_st.tgl_cnt = 3'h0;
				end else if ({pins.page_latch, pins.strobe_action, pins.byte_select_lo}
						!= ENTRY_PATTERN) begin
					nxt_st.mode = MODE_FAIL;
				end else if (st_ff.ent_cnt == 2'(ENTRY_QUIET_CYC - 1)) begin
					nxt_st.mode = MODE_PROG;
				end else begin
					nxt_st.ent_cnt = st_ff.ent_cnt + 2'h1;
				end
			end
			MODE_PROG, MODE_FAIL: begin
				if (!pins.qualify) begin
					nxt_st.mode = MODE_OFF;
					nxt_st.tgl_cnt = 3'h0;
					nxt_st.cmd = CMD_NOP;
				end
			end
			default: nxt_st.mode = MODE_OFF;
		endcase

		// Loads on the load strobe; registers otherwise hold their value
		if (ls_rise) begin
			case (pins.strobe_action)
				SA_ADDR: begin
					case (bs)
						BS_LOW: nxt_st.addr[7:0] = pins.data;
						BS_HIGH: nxt_st.addr[15:8] = pins.data;
						BS_EXT: nxt_st.addr[23:16] = pins.data;
						default: nxt_st.addr = st_ff.addr;
					endcase
				end
				SA_DATA: begin
					if (!pins.byte_select_hi) begin
						if (pins.byte_select_lo) begin
							nxt_st.dhi = pins.data;
						end else begin
							nxt_st.dlo = pins.data;
						end
					end
				end
				SA_CMD: begin
					nxt_st.cmd = pins.data;
					// No-op drops any write that has not started yet
					if (pins.data == CMD_NOP && !st_ff.busy) begin
						nxt_st.op = OP_NONE;
					end
				end
				default: nxt_st.cmd = st_ff.cmd;
			endcase
		end

		// Write strobe performs the loaded command; ignored while busy
		if (wr_fall && !st_ff.busy) begin
			case (st_ff.cmd)
				CMD_ERASE: nxt_st.op = OP_ERASE;
				CMD_WR_FLASH: nxt_st.op = (bs == BS_LOW) ? OP_FLASH_PAGE : OP_NONE;
				CMD_WR_EE: nxt_st.op = (bs == BS_LOW) ? OP_EE_PAGE : OP_NONE;
				CMD_WR_FUSE: nxt_st.op = (bs != BS_FHIGH) ? OP_FUSE : OP_NONE;
				CMD_WR_LOCK: nxt_st.op = OP_LOCK;
				default: nxt_st.op = OP_NONE;
			endcase
			nxt_st.fsel = bs;
			nxt_st.start = (nxt_st.op != OP_NONE);
			nxt_st.busy = (nxt_st.op != OP_NONE);
		end

		// Completion; lock bits are released only once memory is erased
		if (st_ff.busy && i_nvm_done) begin
			nxt_st.busy = 1'b0;
			nxt_st.op = OP_NONE;
			case (st_ff.op)
				OP_ERASE: nxt_st.lock = LOCK_ERASED;
				OP_FUSE: begin
					case (st_ff.fsel)
						BS_LOW: nxt_st.fuse_lo = st_ff.dlo;
						BS_HIGH: nxt_st.fuse_hi = st_ff.dlo;
						default: nxt_st.fuse_ext = st_ff.dlo;
					endcase
				end
				// Lock bits can only be programmed here, never released
				OP_LOCK: nxt_st.lock = st_ff.lock & st_ff.dlo;
				default: nxt_st.op = OP_NONE;
			endcase
		end

		// Readback path, driven only in programming mode with enable low
		nxt_st.oe_n = pins.output_enable_n || !in_prog;
		nxt_st.dout = read_byte(st_ff.cmd, bs, st_ff);
		nxt_st.pbuf_rd = pbuf[i_pbuf_idx];
	end

	// ----------------------------------------------------------------
	// Registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			st_ff <= ST_RST;
		end else if (i_ce) begin
			st_ff <= nxt_st;
		end
	end

	// Page buffer, word picked by the low address bits
	always_ff @(posedge i_clk) begin
		if (i_ce && pbuf_we) begin
			pbuf[st_ff.addr[PAGE_WORD_BITS-1:0]] <= {st_ff.dhi, st_ff.dlo};
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign o_data = st_ff.dout;
	assign o_data_oe_n = st_ff.oe_n;
	assign o_ready_busy_n = !st_ff.busy;
	assign o_prog_mode = in_prog;
	assign o_pbuf_word = st_ff.pbuf_rd;
	// Page address is the upper bits; memory side ignores the word bits
	assign o_nvm_req = '{
		start: st_ff.start, op: st_ff.op, addr: st_ff.addr,
		wdata: st_ff.dlo,
		keep_eeprom: !st_ff.fuse_hi[KEEP_EE_BIT]
	};

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (!i_arst_n);

	sequence s_cmd_load;
		i_ce && ls_rise && pins.strobe_action == SA_CMD;
	endsequence

	sequence s_erase_go;
		i_ce && wr_fall && !st_ff.busy && st_ff.cmd == CMD_ERASE;
	endsequence

	property p_cmd_load;
		s_cmd_load |=> st_ff.cmd == $past(pin_data);
	endproperty
	a_cmd_load: assert property (p_cmd_load) else $error("command byte not loaded");

	property p_erase_busy;
		s_erase_go |=> !o_ready_busy_n && o_nvm_req.op == OP_ERASE && o_nvm_req.start;
	endproperty
	a_erase_busy: assert property (p_erase_busy) else $error("erase did not go busy");

	property p_busy_hold;
		!o_ready_busy_n && !(i_ce && i_nvm_done) |=> !o_ready_busy_n;
	endproperty
	a_busy_hold: assert property (p_busy_hold) else $error("busy dropped early");

	property p_oe_off;
		i_ce && pins.output_enable_n |=> o_data_oe_n;
	endproperty
	a_oe_off: assert property (p_oe_off) else $error("bus driven with enable high");

	property p_addr_hi;
		i_ce && ls_rise && pins.strobe_action == SA_ADDR && bs == BS_HIGH
			|=> st_ff.addr[15:8] == $past(pin_data) && $stable(st_ff.addr[7:0]);
	endproperty
	a_addr_hi: assert property (p_addr_hi) else $error("address high byte wrong");

	property p_addr_rsv;
		i_ce && ls_rise && pins.strobe_action == SA_ADDR && bs == BS_FHIGH
			|=> $stable(st_ff.addr);
	endproperty
	a_addr_rsv: assert property (p_addr_rsv) else $error("reserved select changed address");

	property p_data_hi;
		i_ce && ls_rise && pins.strobe_action == SA_DATA && bs == BS_HIGH
			|=> st_ff.dhi == $past(pin_data) && $stable(st_ff.dlo);
	endproperty
	a_data_hi: assert property (p_data_hi) else $error("data high byte wrong");

	property p_entry_fail;
		i_ce && st_ff.mode == MODE_ENTRY && pins.qualify
			&& {pins.page_latch, pins.strobe_action, pins.byte_select_lo} != ENTRY_PATTERN
			|=> st_ff.mode == MODE_FAIL ##1 !o_prog_mode;
	endproperty
	a_entry_fail: assert property (p_entry_fail) else $error("entry not refused");

	property p_lock_after_erase;
		i_ce && st_ff.busy && st_ff.op == OP_ERASE && !i_nvm_done |=> st_ff.lock == $past(st_ff.lock);
	endproperty
	a_lock_after_erase: assert property (p_lock_after_erase) else $error("lock cleared early");

	property p_lock_clear;
		i_ce && st_ff.busy && st_ff.op == OP_ERASE && i_nvm_done
			|=> st_ff.lock == LOCK_ERASED && o_ready_busy_n;
	endproperty
	a_lock_clear: assert property (p_lock_clear) else $error("lock not cleared");

	property p_page_prog;
		i_ce && wr_fall && !st_ff.busy && st_ff.cmd == CMD_WR_FLASH && bs == BS_LOW
			|=> o_nvm_req.op == OP_FLASH_PAGE ##1 !o_nvm_req.start;
	endproperty
	a_page_prog: assert property (p_page_prog) else $error("page program not started");

endmodule

`default_nettype wire

/* ppp_mem_model.sv */
`timescale 1ns/1ps
`default_nettype none

// Memory-side stand-in: ends every started operation after a fixed busy time
module ppp_mem_model
	import ppp_pkg::*;
#(
	parameter int BUSY_CYC = 30,
	parameter logic [7:0] SIG_SEED = 8'h5a, // Arbitrary value
	parameter logic [7:0] CAL_VAL = 8'ha5
) (
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_arst_n,
	// Request and answers
	input wire ppp_nvm_req_s i_req,
	output logic o_done,
	output logic [15:0] o_flash_word,
	output logic [7:0] o_ee_byte,
	output logic [7:0] o_sig_byte,
	output logic [7:0] o_cal_byte
);
	// ----------------------------------------------------------------
	// Busy timer
	// ----------------------------------------------------------------
	int cnt_ff;
	logic done_ff;

	// Done is one cycle wide; a start while counting restarts the wait
	always_ff @(posedge i_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			cnt_ff <= 0;
			done_ff <= 1'b0;
		end else begin
			done_ff <= (cnt_ff == 1);
			if (i_req.start)
				cnt_ff <= BUSY_CYC;
			else if (cnt_ff != 0)
				cnt_ff <= cnt_ff - 1;
		end
	end
	assign o_done = done_ff;

	// Read data follows the address, calibration byte fixed, so the bench can predict every byte
	assign o_flash_word = ~i_req.addr[15:0];
	assign o_ee_byte = i_req.addr[7:0] ^ 8'h3c;
	assign o_sig_byte = i_req.addr[7:0] ^ SIG_SEED;
	assign o_cal_byte = CAL_VAL;
endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	import ppp_pkg::*;
	// ----------------------------------------------------------------
	// Pins, bus and bookkeeping
	// ----------------------------------------------------------------
	logic clk = 1'b0;
	logic arst_n = 1'b0;
	logic ce = 1'b1;
	logic qual = 1'b0;
	logic ls = 1'b0;
	logic [1:0] sa = 2'h3;
	logic bsh = 1'b0;
	logic bsl = 1'b0;
	logic pl = 1'b0;
	logic wr_n = 1'b1;
	logic oe_n = 1'b1;
	logic [7:0] din = 8'h00;
	logic [5:0] pidx = 6'h00;
	wire logic [7:0] bus;
	logic [7:0] odata, eeb, sigb, calb;
	logic doe_n, rdy, pmode, done;
	logic [15:0] fw, pword;
	ppp_nvm_req_s req;
	int err_count = 0;
	int checks_done = 0;
	int cyc = 0;
	logic [7:0] fv [3] = '{8'h64, 8'h91, 8'hfd};
	logic [1:0] fs [3] = '{BS_LOW, BS_HIGH, BS_EXT};
	logic [7:0] wc [3] = '{CMD_ERASE, CMD_WR_FLASH, CMD_WR_EE};
	ppp_op_e wo [3] = '{OP_ERASE, OP_FLASH_PAGE, OP_EE_PAGE};
	logic [7:0] rc [5] = '{CMD_RD_FLASH, CMD_RD_FLASH, CMD_RD_EE, CMD_RD_SIG, CMD_RD_SIG};
	logic [7:0] rx [5] = '{8'hc0, 8'hed, 8'h03, 8'h65, 8'ha5};

	// Device drives the shared bus only while its enable is low
	assign bus = doe_n ? din : odata;
	always #25 clk = ~clk;

	ppp_port dut (.i_clk(clk), .i_arst_n(arst_n), .i_ce(ce), .i_prog_qualify(qual),
		.i_load_strobe(ls), .i_strobe_action(sa), .i_byte_select_hi(bsh),
		.i_byte_select_lo(bsl), .i_page_latch(pl), .i_write_strobe_n(wr_n),
		.i_output_enable_n(oe_n), .i_data(bus), .o_data(odata), .o_data_oe_n(doe_n),
		.o_ready_busy_n(rdy), .o_prog_mode(pmode), .o_nvm_req(req), .i_nvm_done(done),
		.i_flash_word(fw), .i_ee_byte(eeb), .i_sig_byte(sigb), .i_cal_byte(calb),
		.i_pbuf_idx(pidx), .o_pbuf_word(pword));

	ppp_mem_model mem (.i_clk(clk), .i_arst_n(arst_n), .i_req(req), .o_done(done),
		.o_flash_word(fw), .o_ee_byte(eeb), .o_sig_byte(sigb), .o_cal_byte(calb));

	// ----------------------------------------------------------------
	// Access tasks
	// ----------------------------------------------------------------
	task automatic close_out();
		if (err_count == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic chk_val(input string nm, input logic [23:0] exp, input logic [23:0] got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask

	task automatic chk_bit(input string nm, input logic exp, input logic got);
		checks_done++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %b seen %b", nm, exp, got);
		end
	endtask

	// Four cycles keep every pin steady past the two-flop synchroniser
	task automatic half();
		repeat (4) @(negedge clk);
	endtask

	task automatic load(input logic [1:0] a, input logic [1:0] b, input logic [7:0] d);
		sa = a;
		{bsh, bsl} = b;
		din = d;
		half();
		ls = 1'b1;
		half();
		ls = 1'b0;
		half();
	endtask

	task automatic wr(input logic [1:0] b);
		{bsh, bsl} = b;
		half();
		wr_n = 1'b0;
		half();
		wr_n = 1'b1;
		half();
	endtask

	task automatic rd(input logic [1:0] b, input logic [7:0] exp);
		{bsh, bsl} = b;
		oe_n = 1'b0;
		repeat (5) @(negedge clk);
		chk_bit("data_oe_n", 1'b0, doe_n);
		chk_val("read_byte", 24'(exp), 24'(odata));
		oe_n = 1'b1;
		half();
	endtask

	task automatic wait_rdy();
		int n = 0;
		while (rdy !== 1'b1 && n < 200) begin
			@(negedge clk);
			n++;
		end
		chk_bit("ready_busy_n", 1'b1, rdy);
	endtask

	task automatic word(input logic [7:0] a, input logic [15:0] d);
		load(SA_ADDR, BS_LOW, a);
		load(SA_DATA, BS_LOW, d[7:0]);
		load(SA_DATA, BS_HIGH, d[15:8]);
		latch();
	endtask

	// Page latch pulse with the low select up
	task automatic latch();
		{bsh, bsl} = 2'h1;
		half();
		pl = 1'b1;
		half();
		pl = 1'b0;
		half();
	endtask

	task automatic enter(input int n, input logic glitch);
		qual = 1'b0;
		pl = 1'b0;
		sa = 2'h0;
		bsl = 1'b0;
		half();
		repeat (n) begin
			ls = 1'b1;
			half();
			ls = 1'b0;
			half();
		end
		qual = 1'b1;
		@(negedge clk);
		pl = glitch;
		repeat (1000) @(negedge clk); // Settle 50 us before any command
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		cyc++;
		if (cyc == 20000) begin
			err_count++;
			close_out();
		end
	end

	initial begin
		repeat (3) @(negedge clk);
		arst_n = 1'b1;
		chk_bit("ready_busy_n", 1'b1, rdy);
		chk_bit("data_oe_n", 1'b1, doe_n);
		enter(5, 1'b0); // Too few toggles
		chk_bit("prog_mode", 1'b0, pmode);
		enter(6, 1'b1);
		chk_bit("prog_mode", 1'b0, pmode);
		enter(6, 1'b0);
		chk_bit("prog_mode", 1'b1, pmode);
		chk_bit("data_oe_n", 1'b1, doe_n);
		// Erase and each page-type write start their own operation; eeprom not kept by default
		for (int i = 0; i < 3; i++) begin
			load(SA_CMD, BS_LOW, wc[i]);
			wr(BS_LOW);
			chk_val("op", 24'(wo[i]), 24'(req.op));
			chk_bit("keep_eeprom", 1'b0, req.keep_eeprom);
			chk_bit("ready_busy_n", 1'b0, rdy);
			wait_rdy();
		end
		load(SA_CMD, BS_LOW, CMD_WR_LOCK);
		load(SA_DATA, BS_LOW, 8'hfc);
		wr(BS_LOW);
		chk_val("op", 24'(OP_LOCK), 24'(req.op));
		wait_rdy();
		load(SA_CMD, BS_LOW, CMD_WR_FUSE);
		for (int i = 0; i < 3; i++) begin
			load(SA_DATA, BS_LOW, fv[i]);
			wr(fs[i]); // Command loaded once serves all three
			chk_val("op", 24'(OP_FUSE), 24'(req.op));
			chk_val("wdata", 24'(fv[i]), 24'(req.wdata));
			wait_rdy();
		end
		for (int e = 0; e < 2; e++) begin
			load(SA_CMD, BS_LOW, CMD_RD_FUSE);
			rd(BS_LOW, 8'h64);
			rd(BS_HIGH, e ? 8'hff : 8'hfc);
			rd(BS_EXT, 8'hfd);
			rd(BS_FHIGH, 8'h91);
			if (e == 0) begin
				load(SA_CMD, BS_LOW, CMD_ERASE);
				wr(BS_LOW);
				chk_bit("keep_eeprom", 1'b1, req.keep_eeprom);
				wait_rdy();
			end
		end
		// Page fill at both ends of the buffer, then reserved selects; no word
		// is all ones, so none may be skipped after the erase
		load(SA_CMD, BS_LOW, CMD_WR_FLASH);
		word(8'h00, 16'h1234);
		word(8'h3f, 16'hbeef);
		load(SA_DATA, 2'h2, 8'h77);
		load(SA_ADDR, BS_FHIGH, 8'haa);
		load(SA_ADDR, BS_HIGH, 8'h12);
		load(SA_ADDR, BS_EXT, 8'h03);
		latch(); // Relatch word 0x3f from the held data bytes
		pidx = 6'h00;
		repeat (2) @(negedge clk);
		chk_val("pbuf_word", 24'h001234, 24'(pword));
		pidx = 6'h3f;
		repeat (2) @(negedge clk);
		chk_val("pbuf_word", 24'h00beef, 24'(pword));
		for (int i = 0; i < 2; i++) begin
			wr(BS_LOW);
			chk_val("op", 24'(OP_FLASH_PAGE), 24'(req.op));
			chk_val("addr", 24'h03123f, req.addr);
			wait_rdy();
		end
		wr(BS_HIGH); // Page program needs select 00
		chk_bit("ready_busy_n", 1'b1, rdy);
		load(SA_CMD, BS_LOW, CMD_NOP);
		wr(BS_LOW);
		chk_bit("ready_busy_n", 1'b1, rdy);
		chk_val("op", 24'(OP_NONE), 24'(req.op));
		// Strobes given while the clock enable is low must be lost
		ce = 1'b0;
		load(SA_CMD, BS_LOW, CMD_ERASE);
		wr(BS_LOW);
		ce = 1'b1;
		half();
		chk_bit("ready_busy_n", 1'b1, rdy);
		chk_val("op", 24'(OP_NONE), 24'(req.op));
		// Read commands against the loaded address
		for (int i = 0; i < 5; i++) begin
			load(SA_CMD, BS_LOW, rc[i]);
			rd({1'b0, i[0] ^ (i > 2)}, rx[i]);
		end
		close_out();
	end
endmodule

`default_nettype wire
